// ==== bis_pkg.sv ====
// Constants for the bridge interrupt status block: register offsets,
// flag positions, access masks and values after reset.
// Assumes byte addresses of 12 bits on the plain register port.
package bis_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFF_INT_STATUS = 12'h600;
  localparam logic [11:0] OFF_INT_ENABLE = 12'h604;

  // Flag positions, shared by the status and the enable register
  localparam int BIT_PCI_ERR_LOG = 31;
  localparam int BIT_PROC_ERR_LOG = 30;
  localparam int BIT_MASTER_PARITY = 29;
  localparam int BIT_PCI_CFG_STATUS = 28;
  localparam int BIT_DMA_PROC_ERR = 27;
  localparam int BIT_DMA_PCI_ERR = 26;
  localparam int BIT_DMA_RESET = 25;
  localparam int BIT_DMA_DONE = 24;
  localparam int BIT_PCI_IRQ_FWD = 23;
  localparam int BIT_PCI_PARITY_ERR = 22;
  localparam int BIT_PCI_SYSTEM_ERR = 21;
  localparam int BIT_PROC_IRQ_FWD = 20;
  localparam int BIT_MAILBOX_LO = 16;
  localparam int BIT_PROC_PARITY_ERR = 15;
  localparam int BIT_POWER_STATE = 14;
  localparam int BIT_OUT_POST_NOT_EMPTY = 13;
  localparam int BIT_IN_POST_NEW = 12;
  localparam int BIT_IN_FREE_EMPTY = 11;
  localparam int BIT_OUT_FREE_EMPTY = 10;
  localparam int BIT_IN_POST_FULL = 9;
  localparam int BIT_OUT_FREE_FULL = 8;
  localparam int BIT_SOFT_IRQ_LO = 0;

  // Latched write-one-to-clear flags
  localparam logic [31:0] W1C_MASK = 32'hffff_d00f;
  // Flags that follow queue state, read only
  localparam logic [31:0] QUEUE_MASK = 32'h0000_2f00;
  // Flags set by a one-cycle pulse rather than a rising level
  localparam logic [31:0] PULSE_MASK = 32'h0000_100f;
  // Writable bits of the enable register
  localparam logic [31:0] ENABLE_MASK = 32'hffff_ff0f;

  // Values after reset
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_LATCHED = 32'h0000_0000;
  localparam logic [31:0] RST_QUEUE = 32'h0000_0c00;
  localparam logic [31:0] RST_PREV = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Pins that pass the synchroniser, asserted-high order
  localparam int PIN_W = 4;
  localparam int PIN_SYSTEM_ERR = 0;
  localparam int PIN_PARITY_ERR = 1;
  localparam int PIN_PCI_IRQ = 2;
  localparam int PIN_PROC_IRQ = 3;

endpackage : bis_pkg

// ==== bis_sync.sv ====
// Two-stage synchroniser for levels entering the core clock domain.
// Assumes an active-low asynchronous reset; the reset value is zero.
`timescale 1ns/1ps
module bis_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_b, // Asynchronous reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [WIDTH-1:0] i_d, // Level from another domain
  output logic [WIDTH-1:0] o_q // Synchronised level
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } bis_sync_t;

  bis_sync_t sync_q;
  bis_sync_t sync_d;

  // First stage feeds only the second stage
  always_comb
  begin
    sync_d = sync_q;
    sync_d.meta = i_d;
    sync_d.sync = sync_q.meta;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_q <= '0;
    end
    else if (i_ce)
    begin
      sync_q <= sync_d;
    end
  end

  assign o_q = sync_q.sync;

endmodule : bis_sync

// ==== bis_top.sv ====
// Interrupt status and enable registers of the bus bridge.
// Assumes same-clock event sources, asynchronous bridge pins, and a plain
// register port whose read data appear one cycle after the read strobe.
// Contract
// - Each latched flag sets when its interrupt condition becomes asserted while its enable is set.
// - Latched flag holds until software writes one; writing zero keeps it.
// - Clearing a latched flag leaves the originating source bit untouched.
// - Master parity flag sets only when enabled and source bit becomes set.
// - Queue state flags follow the queues regardless of their enables.
// - Inbound post new-entry flag sets only when enabled on a posting; W1C.
// - Outbound post not-empty reads one while entries exist; zero after reset.
// - Inbound free empty reads one while empty; one after reset.
// - Outbound free empty reads one while empty; one after reset.
// - Inbound post full reads one while full; zero after reset.
// - Outbound free full reads one while full; zero after reset.
// - W1C flag records PCI system-error input mapped to processor interrupt.
// - W1C flag records PCI parity-error input mapped to processor interrupt.
// - W1C flag records PCI interrupt forwarded to processor-bus interrupt.
// - W1C flag records processor-bus interrupt forwarded to PCI interrupt.
// - Four independent W1C software interrupt flags in bits three to zero.
// - W1C power-state-changed flag sets when the power state changes.
// - Enable register at 604 holds one enable per source; one enables.
`timescale 1ns/1ps
module bis_top
  import bis_pkg::*;
(
  input wire logic i_core_clk, // Core clock, 50 MHz
  input wire logic i_rst_b, // Global reset, active low, asynchronous
  input wire logic i_ce, // Clock enable, freezes all state but the reset synchroniser when low
  // Register port
  input wire logic [ADDR_W-1:0] i_addr, // Byte address
  input wire logic [DATA_W-1:0] i_wr_data, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [DATA_W-1:0] o_rd_data, // Read data, cycle after strobe
  // Same-clock conditions, level, flag on rising edge
  input wire logic i_pci_err_log, // PCI error log holds an entry
  input wire logic i_proc_err_log, // Processor bus error log holds an entry
  input wire logic i_master_parity_source_bit, // Parity detected source bit
  input wire logic i_pci_cfg_status, // A configuration status bit is set
  input wire logic i_dma_proc_err, // DMA processor bus error
  input wire logic i_dma_pci_err, // DMA PCI error
  input wire logic i_dma_reset, // DMA reset
  input wire logic i_dma_done, // DMA done
  input wire logic [3:0] i_mailbox_event, // Mailbox three to zero written
  input wire logic i_proc_parity_err, // Processor bus data parity error
  input wire logic i_power_state_change, // PCI power state changed
  // Same-clock pulses
  input wire logic i_in_post_new_entry, // Address posted to inbound post queue
  input wire logic [3:0] i_soft_irq_set, // Software interrupt three to zero
  // Queue state, same clock
  input wire logic i_out_post_not_empty, // Outbound post queue holds entries
  input wire logic i_in_free_empty, // Inbound free queue empty
  input wire logic i_out_free_empty, // Outbound free queue empty
  input wire logic i_in_post_full, // Inbound post queue full
  input wire logic i_out_free_full, // Outbound free queue full
  // Asynchronous bridge pins, active low
  input wire logic i_pci_serr_b, // PCI system error pin
  input wire logic i_pci_perr_b, // PCI parity error pin
  input wire logic i_pci_irq_b, // PCI interrupt input pin
  input wire logic i_proc_irq_b, // Processor bus interrupt input pin
  // State for the interrupt mapping logic
  output logic [DATA_W-1:0] o_latched_flags, // Latched flags, registered
  output logic [DATA_W-1:0] o_enable // Enable register, registered
);

  typedef struct packed
  {
    logic [31:0] enable;
    logic [31:0] latched;
    logic [31:0] queue;
    logic [31:0] prev;
    logic [31:0] rdata;
  } bis_state_t;

  bis_state_t st_q;
  bis_state_t st_d;

  logic rst_sync_b;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_sync;
  logic [31:0] cond;
  logic [31:0] pulse;
  logic [31:0] rise;
  logic [31:0] set_evt;
  logic [31:0] clr_evt;
  logic [31:0] status_view;
  logic wr_status;
  logic wr_enable;

  // Address match for one register word
  function automatic logic bis_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    bis_hit = (addr == offset);
  endfunction : bis_hit

  // Reset release through two flip-flops
  bis_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(1'b1),
    .i_d(1'b1),
    .o_q(rst_sync_b)
  );

  // Pins are inverted to asserted-high before the synchroniser
  assign pin_raw[PIN_SYSTEM_ERR] = ~i_pci_serr_b;
  assign pin_raw[PIN_PARITY_ERR] = ~i_pci_perr_b;
  assign pin_raw[PIN_PCI_IRQ] = ~i_pci_irq_b;
  assign pin_raw[PIN_PROC_IRQ] = ~i_proc_irq_b;

  bis_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(rst_sync_b),
    .i_ce(i_ce),
    .i_d(pin_raw),
    .o_q(pin_sync)
  );

  // Level conditions placed at their flag positions
  always_comb
  begin
    cond = '0;
    cond[BIT_PCI_ERR_LOG] = i_pci_err_log;
    cond[BIT_PROC_ERR_LOG] = i_proc_err_log;
    cond[BIT_MASTER_PARITY] = i_master_parity_source_bit;
    cond[BIT_PCI_CFG_STATUS] = i_pci_cfg_status;
    cond[BIT_DMA_PROC_ERR] = i_dma_proc_err;
    cond[BIT_DMA_PCI_ERR] = i_dma_pci_err;
    cond[BIT_DMA_RESET] = i_dma_reset;
    cond[BIT_DMA_DONE] = i_dma_done;
    cond[BIT_PCI_IRQ_FWD] = pin_sync[PIN_PCI_IRQ];
    cond[BIT_PCI_PARITY_ERR] = pin_sync[PIN_PARITY_ERR];
    cond[BIT_PCI_SYSTEM_ERR] = pin_sync[PIN_SYSTEM_ERR];
    cond[BIT_PROC_IRQ_FWD] = pin_sync[PIN_PROC_IRQ];
    cond[BIT_MAILBOX_LO +: 4] = i_mailbox_event;
    cond[BIT_PROC_PARITY_ERR] = i_proc_parity_err;
    cond[BIT_POWER_STATE] = i_power_state_change;
  end

  // Pulse sources set their flag directly
  always_comb
  begin
    pulse = '0;
    pulse[BIT_IN_POST_NEW] = i_in_post_new_entry;
    pulse[BIT_SOFT_IRQ_LO +: 4] = i_soft_irq_set;
  end

  assign rise = cond & ~st_q.prev & ~PULSE_MASK;

  assign set_evt = (rise | (pulse & PULSE_MASK)) & st_q.enable & W1C_MASK;

  assign wr_status = i_wr && bis_hit(i_addr, OFF_INT_STATUS);
  assign wr_enable = i_wr && bis_hit(i_addr, OFF_INT_ENABLE);

  assign clr_evt = wr_status ? (i_wr_data & W1C_MASK) : '0;

  assign status_view = (st_q.latched & W1C_MASK) | (st_q.queue & QUEUE_MASK);

  always_comb
  begin
    st_d = st_q;
    st_d.prev = cond;
    st_d.latched = ((st_q.latched & ~clr_evt) | set_evt) & W1C_MASK;
    st_d.queue = '0;
    st_d.queue[BIT_OUT_POST_NOT_EMPTY] = i_out_post_not_empty;
    st_d.queue[BIT_IN_FREE_EMPTY] = i_in_free_empty;
    st_d.queue[BIT_OUT_FREE_EMPTY] = i_out_free_empty;
    st_d.queue[BIT_IN_POST_FULL] = i_in_post_full;
    st_d.queue[BIT_OUT_FREE_FULL] = i_out_free_full;
    if (wr_enable)
    begin
      st_d.enable = i_wr_data & ENABLE_MASK;
    end
    if (i_rd)
    begin
      if (bis_hit(i_addr, OFF_INT_STATUS))
      begin
        st_d.rdata = status_view;
      end
      else if (bis_hit(i_addr, OFF_INT_ENABLE))
      begin
        st_d.rdata = st_q.enable;
      end
      else
      begin
        st_d.rdata = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      st_q.enable <= RST_ENABLE;
      st_q.latched <= RST_LATCHED;
      st_q.queue <= RST_QUEUE;
      st_q.prev <= RST_PREV;
      st_q.rdata <= RD_UNMAPPED;
    end
    else if (i_ce)
    begin
      st_q <= st_d;
    end
  end

  assign o_rd_data = st_q.rdata;
  assign o_latched_flags = st_q.latched;
  assign o_enable = st_q.enable;

endmodule : bis_top

// ==== bis_top_monitor.sv ====
// Checker on the ports of the interrupt status block.
// Assumes the clock enable is held high and no read in the first edges after reset.
`timescale 1ns/1ps
module bis_top_monitor
  import bis_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_b, // Global reset, active low
  input wire logic [ADDR_W-1:0] i_addr, // Byte address
  input wire logic [DATA_W-1:0] i_wr_data, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [DATA_W-1:0] o_rd_data, // Read data
  input wire logic i_master_parity_source_bit, // Parity source bit
  input wire logic i_in_post_new_entry, // Inbound post pulse
  input wire logic [3:0] i_soft_irq_set, // Software interrupt pulses
  input wire logic i_in_free_empty, // Inbound free queue empty
  input wire logic i_pci_serr_b, // System error pin
  input wire logic [DATA_W-1:0] o_latched_flags, // Latched flags
  input wire logic [DATA_W-1:0] o_enable // Enable register
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_serr_fall;
    $fell(i_pci_serr_b) && o_enable[21] ##1 o_enable[21];
  endsequence
  property p_serr;
    s_serr_fall |-> ##[1:3] o_latched_flags[21];
  endproperty
  a_serr: assert property (p_serr) else $error("system error flag missing");
  property p_hold;
    o_latched_flags[24] && !(i_wr && i_addr == OFF_INT_STATUS && i_wr_data[24])
      |=> o_latched_flags[24];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost without clear");
  property p_clear;
    i_wr && i_addr == OFF_INT_STATUS && i_wr_data[0] && !i_soft_irq_set[0]
      |=> !o_latched_flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_soft;
    i_soft_irq_set[1] && o_enable[1] |=> o_latched_flags[1];
  endproperty
  a_soft: assert property (p_soft) else $error("soft flag not set");
  property p_inpost;
    i_in_post_new_entry && o_enable[12] |=> o_latched_flags[12];
  endproperty
  a_inpost: assert property (p_inpost) else $error("new entry flag not set");
  property p_inpost_gate;
    !o_latched_flags[12] && !(i_in_post_new_entry && o_enable[12]) |=> !o_latched_flags[12];
  endproperty
  a_inpost_gate: assert property (p_inpost_gate) else $error("new entry flag set");
  property p_parity;
    $rose(i_master_parity_source_bit) && o_enable[29] |=> o_latched_flags[29];
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag not set");
  property p_parity_gate;
    !o_latched_flags[29] && !o_enable[29] |=> !o_latched_flags[29];
  endproperty
  a_parity_gate: assert property (p_parity_gate) else $error("parity flag set");
  property p_queue;
    i_rd && i_addr == OFF_INT_STATUS |=> o_rd_data[11] == $past(i_in_free_empty, 2);
  endproperty
  a_queue: assert property (p_queue) else $error("free empty bit wrong");
  property p_unmapped;
    i_rd && i_addr != OFF_INT_STATUS && i_addr != OFF_INT_ENABLE |=> o_rd_data == RD_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : bis_top_monitor
bind bis_top bis_top_monitor u_mon (.i_core_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr,
  .i_rd, .o_rd_data, .i_master_parity_source_bit, .i_in_post_new_entry, .i_soft_irq_set,
  .i_in_free_empty, .i_pci_serr_b, .o_latched_flags, .o_enable);

// ==== bis_top_tb.sv ====
// Self-checking bench for the interrupt status block.
// Assumes the block runs with its clock enable held high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module bis_top_tb;
  import bis_pkg::*;
  logic clk, rst_b, wr, rd, ppar, pwr, ipn;
  logic [11:0] addr;
  logic [31:0] wd, rdat, lat, en;
  logic [7:0] lv;
  logic [3:0] mb, si, pin_b;
  logic [4:0] q;
  int n_mismatch = 0;
  int tests_run = 0;
  bis_top DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_addr(addr),
    .i_wr_data(wd), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .i_pci_err_log(lv[7]),
    .i_proc_err_log(lv[6]), .i_master_parity_source_bit(lv[5]), .i_pci_cfg_status(lv[4]),
    .i_dma_proc_err(lv[3]), .i_dma_pci_err(lv[2]), .i_dma_reset(lv[1]), .i_dma_done(lv[0]),
    .i_mailbox_event(mb), .i_proc_parity_err(ppar), .i_power_state_change(pwr),
    .i_in_post_new_entry(ipn), .i_soft_irq_set(si), .i_out_post_not_empty(q[4]),
    .i_in_free_empty(q[3]), .i_out_free_empty(q[2]), .i_in_post_full(q[1]),
    .i_out_free_full(q[0]), .i_pci_serr_b(pin_b[0]), .i_pci_perr_b(pin_b[1]),
    .i_pci_irq_b(pin_b[2]), .i_proc_irq_b(pin_b[3]), .o_latched_flags(lat), .o_enable(en));
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdat)
  endtask : rd_reg
  task automatic pulse(input logic [3:0] s, input logic p);
    @(posedge clk);
    si <= s;
    ipn <= p;
    @(posedge clk);
    si <= 4'h0;
    ipn <= 1'b0;
    #1;
  endtask : pulse
  // Raises or drops every level source and pin, pulses with raising
  task automatic fire(input logic on);
    @(posedge clk);
    lv <= {8{on}};
    mb <= {4{on}};
    ppar <= on;
    pwr <= on;
    pin_b <= {4{!on}};
    pulse({4{on}}, on);
    repeat (6) @(posedge clk);
    #1;
  endtask : fire
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {rst_b, wr, rd, ppar, pwr, ipn, addr, wd, lv, mb, si} = '0;
    pin_b = 4'hf;
    q = 5'h0c;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(OFF_INT_STATUS, RST_QUEUE, "status reset");
    rd_reg(OFF_INT_ENABLE, RST_ENABLE, "enable reset");
    q <= 5'h19;
    fire(1'b1);
    `CHK("gated flags", 32'h0, lat)
    rd_reg(OFF_INT_STATUS, 32'h0000_2900, "queue state");
    fire(1'b0);
    wr_reg(OFF_INT_ENABLE, 32'hffff_ffff);
    rd_reg(OFF_INT_ENABLE, ENABLE_MASK, "enable mask");
    `CHK("enable out", ENABLE_MASK, en)
    fire(1'b1);
    `CHK("all flags", W1C_MASK, lat)
    rd_reg(OFF_INT_STATUS, W1C_MASK | 32'h0000_2900, "status all");
    wr_reg(OFF_INT_STATUS, 32'h0);
    #1;
    `CHK("zero write", W1C_MASK, lat)
    wr_reg(OFF_INT_STATUS, 32'h0100_0000);
    repeat (3) @(posedge clk);
    #1;
    `CHK("held level", W1C_MASK & 32'hfeff_ffff, lat)
    wr_reg(OFF_INT_STATUS, 32'hffff_ffff);
    rd_reg(OFF_INT_STATUS, 32'h0000_2900, "cleared");
    fire(1'b0);
    for (int n = 0; n < 4; n++)
    begin
      pulse(4'h1 << n, 1'b0);
      `CHK("soft flag", 32'h1 << n, lat)
      wr_reg(OFF_INT_STATUS, 32'h1 << n);
    end
    wr_reg(OFF_INT_ENABLE, ENABLE_MASK & 32'hffff_efff);
    pulse(4'h0, 1'b1);
    `CHK("post gated", 32'h0, lat)
    wr_reg(OFF_INT_ENABLE, ENABLE_MASK);
    pulse(4'h0, 1'b1);
    `CHK("post entry", 32'h0000_1000, lat)
    rd_reg(12'h608, RD_UNMAPPED, "unmapped");
    wr_reg(12'h608, 32'h0);
    rd_reg(OFF_INT_ENABLE, ENABLE_MASK, "enable kept");
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("mid reset", RST_LATCHED, lat)
    summarize();
  end
endmodule : bis_top_tb
